// ---- design/c16ia_top.sv ----
`timescale 1ns/100ps
`include "c16ia_params.svh"

module c16ia_top
   import c16ia_pkg::*;
#(
   parameter logic [6:0] P_SLAVE_ADDR    = `C16IA_SLAVE_ADDR,
   parameter logic [7:0] P_RELOAD_LO     = `C16IA_ADDR_RELOAD_LO,
   parameter logic [7:0] P_RELOAD_HI     = `C16IA_ADDR_RELOAD_HI,
   parameter logic [7:0] P_COUNT_LO      = `C16IA_ADDR_COUNT_LO,
   parameter logic [7:0] P_COUNT_HI      = `C16IA_ADDR_COUNT_HI,
   parameter int         P_GATE_SCL      = `C16IA_GATE_SCL,
   parameter int         P_GATE_TIMEOUT  = 2 * `C16IA_TSTOP_CYC
) (
   // system
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   // i2c pins, sda open drain
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_sda,
   output logic      o_sda_oe_n,
   // counter clock, matrix set/reset, clock-hold option
   input  wire logic i_cnt_clk,
   input  wire logic i_cnt_set,
   input  wire logic i_cnt_rst,
   input  wire logic i_hold_en,
   // counter output
   output logic      o_cnt_pulse
);

   logic [5:0]       pins_s;
   logic             scl_s;
   logic             sda_s;
   logic             cclk_s;
   logic             set_s;
   logic             mrst_s;
   logic             hold_s;
   logic [4:0]       prev_ff;
   logic             scl_rise;
   logic             scl_fall;
   logic             i2c_start;
   logic             i2c_stop;
   logic             cnt_rise;
   logic             counted;
   logic             matrix_ev;

   c16ia_i2c_state_t state_ff;
   logic [7:0]       shift_ff;
   logic [3:0]       bit_cnt_ff;
   logic             rw_ff;
   logic             nack_ff;
   logic [7:0]       ptr_ff;
   logic [7:0]       tx_ff;
   logic             oe_n_ff;
   logic             byte_end;
   logic             addr_match;
   logic             waddr_done;
   logic             wr_stb;
   logic             rd_load;
   logic [7:0]       rd_byte;

   logic [7:0]       stage_lo_ff;
   logic [15:0]      reload_ff;
   logic [15:0]      load_buf_ff;
   logic [15:0]      count_ff;
   c16ia_load_t      load_ff;
   logic             pulse_ff;
   logic             gate_trigger;
   logic             gate_active;

   // every pin crosses into i_clk through two flops; i2c lines idle high
   c16ia_sync #(
      .WIDTH   (6),
      .RST_VAL (64'h3)
   ) u_sync (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_async   ({i_hold_en, i_cnt_rst, i_cnt_set, i_cnt_clk, i_sda, i_scl}),
      .o_sync    (pins_s)
   );

   assign scl_s  = pins_s[0];
   assign sda_s  = pins_s[1];
   assign cclk_s = pins_s[2];
   assign set_s  = pins_s[3];
   assign mrst_s = pins_s[4];
   assign hold_s = pins_s[5];

   // previous synchronised levels for edge finding
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         prev_ff <= 5'h03;
      end else begin
         prev_ff <= {mrst_s, set_s, cclk_s, sda_s, scl_s};
      end
   end

   // bus events; start and stop only while scl stays high
   assign scl_rise  = scl_s && !prev_ff[0];
   assign scl_fall  = !scl_s && prev_ff[0];
   assign i2c_start = scl_s && prev_ff[0] && prev_ff[1] && !sda_s;
   assign i2c_stop  = scl_s && prev_ff[0] && !prev_ff[1] && sda_s;

   // counter events
   assign cnt_rise  = cclk_s && !prev_ff[2];
   assign counted   = cnt_rise && !gate_active;
   assign matrix_ev = (set_s && !prev_ff[3]) || (mrst_s && !prev_ff[4]);

   // decode of the byte just shifted in
   assign byte_end   = scl_fall && (bit_cnt_ff == `C16IA_BYTE_BITS);
   assign addr_match = (shift_ff[7:1] == P_SLAVE_ADDR);
   assign waddr_done = (state_ff == ST_WADDR) && byte_end;
   assign wr_stb     = (state_ff == ST_WDATA) && byte_end;
   assign rd_load    = scl_fall && (((state_ff == ST_AACK) && rw_ff) ||
                                    ((state_ff == ST_RACK) && !nack_ff));

   // read mux; live count comes straight off the count chain
   always_comb begin
      if (ptr_ff == P_RELOAD_LO) begin
         rd_byte = reload_ff[7:0];
      end else if (ptr_ff == P_RELOAD_HI) begin
         rd_byte = reload_ff[15:8];
      end else if (ptr_ff == P_COUNT_LO) begin
         rd_byte = count_ff[7:0];
      end else if (ptr_ff == P_COUNT_HI) begin
         rd_byte = count_ff[15:8];
      end else begin
         rd_byte = `C16IA_READ_FILL;
      end
   end

   // i2c target: shift on scl rise, drive sda on scl fall
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_ff   <= ST_IDLE;
         shift_ff   <= 8'h00;
         bit_cnt_ff <= 4'h0;
         rw_ff      <= 1'b0;
         nack_ff    <= 1'b1;
         ptr_ff     <= 8'h00;
         tx_ff      <= 8'h00;
         oe_n_ff    <= 1'b1;
      end else if (i2c_start) begin
         state_ff   <= ST_ADDR;
         bit_cnt_ff <= 4'h0;
         oe_n_ff    <= 1'b1;
      end else if (i2c_stop) begin
         state_ff   <= ST_IDLE;
         oe_n_ff    <= 1'b1;
      end else if (rd_load) begin
         // first bit goes out on the same fall that ends the ack
         state_ff   <= ST_RDATA;
         oe_n_ff    <= rd_byte[7];
         tx_ff      <= {rd_byte[6:0], 1'b0};
         bit_cnt_ff <= 4'h1;
         ptr_ff     <= ptr_ff + 8'h01;
      end else begin
         case (state_ff)
            ST_ADDR, ST_WADDR, ST_WDATA: begin
               if (scl_rise) begin
                  shift_ff   <= {shift_ff[6:0], sda_s};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end else if (byte_end) begin
                  bit_cnt_ff <= 4'h0;
                  if (state_ff == ST_ADDR) begin
                     if (addr_match) begin
                        oe_n_ff  <= 1'b0;
                        rw_ff    <= shift_ff[0];
                        state_ff <= ST_AACK;
                     end else begin
                        state_ff <= ST_IDLE;
                     end
                  end else begin
                     // word address loads the pointer, data bumps it
                     ptr_ff   <= (state_ff == ST_WADDR) ? shift_ff : ptr_ff + 8'h01;
                     oe_n_ff  <= 1'b0;
                     state_ff <= ST_WACK;
                  end
               end
            end
            ST_AACK, ST_WACK: begin
               if (scl_fall) begin
                  oe_n_ff  <= 1'b1;
                  state_ff <= (state_ff == ST_AACK) ? ST_WADDR : ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (scl_fall) begin
                  if (bit_cnt_ff == `C16IA_BYTE_BITS) begin
                     oe_n_ff    <= 1'b1;
                     bit_cnt_ff <= 4'h0;
                     state_ff   <= ST_RACK;
                  end else begin
                     oe_n_ff    <= tx_ff[7];
                     tx_ff      <= {tx_ff[6:0], 1'b0};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  nack_ff <= sda_s;
               end else if (scl_fall) begin
                  state_ff <= ST_IDLE; // a nack ends the read
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   assign o_sda      = 1'b0;
   assign o_sda_oe_n = oe_n_ff;

   // reload register; low byte waits in a stage until the high byte lands,
   // so the count chain never sees a half-written reload value
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         stage_lo_ff <= 8'(`C16IA_RELOAD_RST);
         reload_ff   <= `C16IA_RELOAD_RST;
      end else if (wr_stb) begin
         if (ptr_ff == P_RELOAD_LO) begin
            stage_lo_ff <= shift_ff;
         end
         if (ptr_ff == P_RELOAD_HI) begin
            reload_ff <= {shift_ff, stage_lo_ff};
         end
      end
   end

   // clock hold window, opened by a reload word address
   assign gate_trigger = waddr_done && hold_s &&
                         ((shift_ff == P_RELOAD_LO) || (shift_ff == P_RELOAD_HI));

   c16ia_gate #(
      .SCL_PERIODS (P_GATE_SCL),
      .TIMEOUT_CYC (P_GATE_TIMEOUT)
   ) u_gate (
      .i_clk      (i_clk),
      .i_sys_rst  (i_sys_rst),
      .i_trigger  (gate_trigger),
      .i_scl_rise (scl_rise),
      .o_active   (gate_active)
   );

   // load progress; set/reset arms a two-edge load, reset arms one too
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || matrix_ev) begin
         load_ff <= LD_ARMED;
      end else if (counted) begin
         case (load_ff)
            LD_ARMED:  load_ff <= LD_STAGED;
            LD_STAGED: load_ff <= LD_IDLE;
            default:   load_ff <= LD_IDLE;
         endcase
      end
   end

   // first counted rise of a load captures the reload value
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         load_buf_ff <= `C16IA_RELOAD_RST;
      end else if (counted && load_ff == LD_ARMED) begin
         load_buf_ff <= reload_ff;
      end
   end

   // count chain; down-counting only, so no overflow path exists
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         count_ff <= `C16IA_COUNT_RST;
      end else if (counted && !matrix_ev) begin
         case (load_ff)
            LD_STAGED: count_ff <= load_buf_ff;
            LD_IDLE: begin
               if (count_ff == 16'h0000) begin
                  count_ff <= reload_ff;
               end else begin
                  count_ff <= count_ff - 16'h0001;
               end
            end
            default: count_ff <= count_ff;
         endcase
      end
   end

   // one i_clk-wide pulse per underflow, never from a write
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pulse_ff <= 1'b0;
      end else begin
         pulse_ff <= counted && !matrix_ev && load_ff == LD_IDLE &&
                     count_ff == 16'h0000;
      end
   end

   assign o_cnt_pulse = pulse_ff;

   a_count_down: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      counted && !matrix_ev && load_ff == LD_IDLE && count_ff != 16'h0000
      |=> count_ff == $past(count_ff) - 16'h0001
   ) else $error("count did not fall by one");

   a_underflow_load: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      counted && !matrix_ev && load_ff == LD_IDLE && count_ff == 16'h0000
      |=> count_ff == $past(reload_ff) && o_cnt_pulse
   ) else $error("underflow did not reload and pulse");

   a_gated_edge: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      cnt_rise && gate_active |=> $stable(count_ff) && !o_cnt_pulse
   ) else $error("counter moved inside hold window");

   a_no_hold_gate: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      !hold_s && !gate_active |=> !gate_active
   ) else $error("hold window opened with hold disabled");

   a_two_edge_load: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      counted && !matrix_ev && load_ff == LD_ARMED |=> $stable(count_ff) && load_ff == LD_STAGED
   ) else $error("load finished before two counter edges");

   a_hi_commit: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      wr_stb && ptr_ff == P_RELOAD_HI
      |=> reload_ff == {$past(shift_ff), $past(stage_lo_ff)}
   ) else $error("reload not committed from low stage and high byte");

   a_live_read: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      rd_load && ptr_ff == P_COUNT_LO
      |=> tx_ff == {$past(count_ff[6:0]), 1'b0} && oe_n_ff == $past(count_ff[7])
   ) else $error("live count read not taken from count chain");

   a_gate_start: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      waddr_done && hold_s && shift_ff == P_RELOAD_LO |=> gate_active [*2]
   ) else $error("reload address did not open hold window");

   a_single_pulse: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      o_cnt_pulse |=> !o_cnt_pulse
   ) else $error("counter pulse longer than one cycle");

endmodule

// ---- design/c16ia_params.svh ----
`ifndef C16IA_PARAMS_SVH
`define C16IA_PARAMS_SVH

// i2c byte addresses of counter instance zero
`define C16IA_ADDR_RELOAD_LO 8'hc5
`define C16IA_ADDR_RELOAD_HI 8'hc6
`define C16IA_ADDR_COUNT_LO  8'heb
`define C16IA_ADDR_COUNT_HI  8'hec

// reset values, slave address and unmapped read fill
`define C16IA_RELOAD_RST     16'h0000
`define C16IA_COUNT_RST      16'h0000
`define C16IA_SLAVE_ADDR     7'h08
`define C16IA_READ_FILL      8'h00

// i2c framing
`define C16IA_BYTE_BITS      4'h8

// clock-hold window: two nine-bit frames of scl periods
`define C16IA_GATE_FRAMES    2
`define C16IA_FRAME_BITS     9
`define C16IA_GATE_SCL       (`C16IA_GATE_FRAMES * `C16IA_FRAME_BITS)

// time base and hold-window time cap
`define C16IA_CLK_PERIOD_NS  10
`define C16IA_TSTOP_US       45
`define C16IA_TSTOP_CYC      ((`C16IA_TSTOP_US * 1000) / `C16IA_CLK_PERIOD_NS)

`endif

// ---- design/c16ia_pkg.sv ----
package c16ia_pkg;

   // i2c target protocol states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_AACK,
      ST_WADDR,
      ST_WACK,
      ST_WDATA,
      ST_RDATA,
      ST_RACK
   } c16ia_i2c_state_t;

   // reload load progress, counted in counter-clock edges
   typedef enum logic [1:0] {
      LD_IDLE,
      LD_ARMED,
      LD_STAGED
   } c16ia_load_t;

endpackage

// ---- design/c16ia_sync.sv ----
`timescale 1ns/100ps

module c16ia_sync #(
   parameter int          WIDTH   = 1,
   parameter logic [63:0] RST_VAL = 64'h0
) (
   // system
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   // asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   if (WIDTH < 1 || WIDTH > 64) begin
      $error("c16ia_sync: WIDTH out of range");
   end

   // two flops per bit; the first is seen only by the second
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         meta_ff <= RST_VAL[WIDTH-1:0];
         sync_ff <= RST_VAL[WIDTH-1:0];
      end else begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
      end
   end

   assign o_sync = sync_ff;

endmodule

// ---- design/c16ia_gate.sv ----
`timescale 1ns/100ps
`include "c16ia_params.svh"

module c16ia_gate #(
   parameter int SCL_PERIODS = `C16IA_GATE_SCL,
   parameter int TIMEOUT_CYC = 2 * `C16IA_TSTOP_CYC
) (
   // system
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   // window start and i2c clock edges
   input  wire logic i_trigger,
   input  wire logic i_scl_rise,
   // window open
   output logic      o_active
);

   localparam int SW = $clog2(SCL_PERIODS + 1);
   localparam int TW = $clog2(TIMEOUT_CYC + 1);
   localparam logic [SW-1:0] SCL_LAST = SW'(SCL_PERIODS - 1);
   localparam logic [TW-1:0] TO_LAST  = TW'(TIMEOUT_CYC - 1);

   logic          active_ff;
   logic [SW-1:0] scl_cnt_ff;
   logic [TW-1:0] to_cnt_ff;
   logic          scl_done;
   logic          to_done;

   if (SCL_PERIODS < 1 || TIMEOUT_CYC < SCL_PERIODS) begin
      $error("c16ia_gate: window lengths cannot be served");
   end

   assign scl_done = i_scl_rise && (scl_cnt_ff == SCL_LAST);
   // cap guards against a host that stops clocking scl mid-window
   assign to_done  = (to_cnt_ff == TO_LAST);

   // window flag; a new trigger restarts it
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         active_ff <= 1'b0;
      end else if (i_trigger) begin
         active_ff <= 1'b1;
      end else if (active_ff && (scl_done || to_done)) begin
         active_ff <= 1'b0;
      end
   end

   // scl period count inside the window
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || i_trigger || !active_ff) begin
         scl_cnt_ff <= '0;
      end else if (i_scl_rise) begin
         scl_cnt_ff <= scl_cnt_ff + SW'(1);
      end
   end

   // time cap count inside the window
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || i_trigger || !active_ff) begin
         to_cnt_ff <= '0;
      end else begin
         to_cnt_ff <= to_cnt_ff + TW'(1);
      end
   end

   assign o_active = active_ff;

   a_gate_length: assert property (
      @(posedge i_clk) disable iff (i_sys_rst)
      active_ff && !i_trigger && i_scl_rise && scl_cnt_ff == SCL_LAST |=> !active_ff
   ) else $error("hold window did not close after its scl periods");

endmodule

// ---- sim/c16ia_i2c_master.sv ----
`timescale 1ns/100ps

// bit-banged i2c host, a quarter of the scl period per step
module c16ia_i2c_master #(
   parameter realtime P_QTR = 31.25
) (
   // wired sda level, pull-up included
   input  wire logic i_sda,
   // scl driven, sda released when high
   output logic      o_scl,
   output logic      o_sda_rel
);
   // idle bus: scl stands high between frames
   initial begin
      o_scl     = 1'b1;
      o_sda_rel = 1'b1;
   end

   // start, also a repeated start from scl low
   task automatic start();
      #P_QTR o_sda_rel = 1'b1;
      #P_QTR o_scl     = 1'b1;
      #P_QTR o_sda_rel = 1'b0;
      #P_QTR o_scl     = 1'b0;
   endtask

   // stop: sda rises while scl is high
   task automatic stop();
      #P_QTR o_sda_rel = 1'b0;
      #P_QTR o_scl     = 1'b1;
      #P_QTR o_sda_rel = 1'b1;
      #P_QTR;
   endtask

   // sda changes only with scl low, sampled mid high phase
   task automatic xbit(input logic b, output logic r);
      #P_QTR o_sda_rel = b;
      #P_QTR o_scl     = 1'b1;
      #P_QTR r         = i_sda;
      #P_QTR o_scl     = 1'b0;
   endtask

   // eight bits msb first, then the acknowledge slot
   task automatic xbyte(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
      xbit(ack_in, ack);
   endtask
endmodule

// ---- sim/c16ia_bench.sv ----
`timescale 1ns/100ps
`include "c16ia_params.svh"

module c16ia_bench;
   localparam logic [6:0] SA    = `C16IA_SLAVE_ADDR;
   localparam logic [7:0] A_RLO = `C16IA_ADDR_RELOAD_LO;
   localparam logic [7:0] A_CLO = `C16IA_ADDR_COUNT_LO;
   localparam int         LIMIT = 60000;
   localparam int         NROW  = 5;

   logic        i_clk, i_sys_rst, i_cnt_clk, i_cnt_set, i_cnt_rst, i_hold_en;
   logic        scl, sda_rel, sda, o_sda, o_sda_oe_n, o_cnt_pulse, run;
   logic [15:0] v;
   int          rises, pulses, cyc, bad_count, tests_run, p, r0;

   // table rows: reload, rises after the event, reset or set, count, pulses
   logic [15:0] row_rel [NROW] = '{16'h00ff, 16'h0101, 16'h0003, 16'h0000, 16'hffff};
   int          row_n   [NROW] = '{2, 7, 6, 4, 3};
   logic        row_rst [NROW] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   logic [15:0] row_cnt [NROW] = '{16'h00ff, 16'h00fc, 16'h0003, 16'h0000, 16'hfffe};
   int          row_np  [NROW] = '{0, 0, 1, 2, 0};

   // open-drain sda with pull-up: low if either party pulls
   assign sda = sda_rel & (o_sda_oe_n | o_sda);

   c16ia_top #(.P_GATE_TIMEOUT(400)) u_c16ia_top (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda),
      .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_cnt_clk(i_cnt_clk),
      .i_cnt_set(i_cnt_set), .i_cnt_rst(i_cnt_rst), .i_hold_en(i_hold_en),
      .o_cnt_pulse(o_cnt_pulse));

   c16ia_i2c_master u_c16ia_i2c_master (.i_sda(sda), .o_scl(scl), .o_sda_rel(sda_rel));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // counter clock 200 ns period; always ends on a low phase, limit cuts hangs
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (o_cnt_pulse === 1'b1) pulses <= pulses + 1;
      if ((run || i_cnt_clk) && cyc % 10 == 0) begin
         i_cnt_clk <= ~i_cnt_clk;
         if (!i_cnt_clk) rises <= rises + 1;
      end
      if (cyc == LIMIT) begin
         bad_count++;
         test_done();
      end
   end

   task automatic test_done();
      if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // n counter-clock rises, then the clock is parked low; n of 0 only parks it
   task automatic tick(input int n);
      int t;
      t = rises + n;
      if (n > 0) begin
         run <= 1'b1;
         wait (rises >= t);
      end
      run <= 1'b0;
      repeat (2) @(posedge i_clk);
      wait (i_cnt_clk == 1'b0);
      repeat (6) @(posedge i_clk);
   endtask

   // matrix set or reset pulse, counter clock kept apart
   task automatic ev(input logic use_rst);
      @(posedge i_clk);
      i_cnt_set <= !use_rst;
      i_cnt_rst <= use_rst;
      repeat (4) @(posedge i_clk);
      i_cnt_set <= 1'b0;
      i_cnt_rst <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask

   // write n bytes from word address a, low byte first
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
      logic [7:0] q;
      logic       ack;
      u_c16ia_i2c_master.start();
      u_c16ia_i2c_master.xbyte({SA, 1'b0}, 1'b1, q, ack);
      chk("address ack", 16'h0000, {15'h0000, ack});
      u_c16ia_i2c_master.xbyte(a, 1'b1, q, ack);
      for (int i = 0; i < n; i++) u_c16ia_i2c_master.xbyte(d[8*i +: 8], 1'b1, q, ack);
      u_c16ia_i2c_master.stop();
   endtask

   // two-byte read through a repeated start, nack on the last byte
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      logic [7:0] q;
      logic       ack;
      u_c16ia_i2c_master.start();
      u_c16ia_i2c_master.xbyte({SA, 1'b0}, 1'b1, q, ack);
      u_c16ia_i2c_master.xbyte(a, 1'b1, q, ack);
      u_c16ia_i2c_master.start();
      u_c16ia_i2c_master.xbyte({SA, 1'b1}, 1'b1, q, ack);
      u_c16ia_i2c_master.xbyte(8'hff, 1'b0, d[7:0], ack);
      u_c16ia_i2c_master.xbyte(8'hff, 1'b1, d[15:8], ack);
      u_c16ia_i2c_master.stop();
   endtask

   // reset, the table of loads, then the hand-written cases
   initial begin
      {i_sys_rst, i_cnt_clk, i_cnt_set, i_cnt_rst, i_hold_en, run} = 6'h20;
      {rises, pulses, cyc, bad_count, tests_run} = 160'h0;
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      repeat (4) @(posedge i_clk);
      rd(A_RLO, v);
      chk("reload after reset", 16'h0000, v);
      // clock parked during each write, then set or reset restarts the count
      for (int r = 0; r < NROW; r++) begin
         wr(A_RLO, row_rel[r], 2);
         ev(row_rst[r]);
         p = pulses;
         tick(row_n[r]);
         rd(A_RLO, v);
         chk("reload", row_rel[r], v);
         rd(A_CLO, v);
         chk("count", row_cnt[r], v);
         chk("pulses", 16'(row_np[r]), 16'(pulses - p));
      end
      wr(A_CLO, 16'h1234, 2);
      rd(A_CLO, v);
      chk("count read only", 16'hfffe, v);
      wr(A_RLO, 16'h0055, 1);
      rd(A_RLO, v);
      chk("lone low byte", 16'hffff, v);
      rd(8'h10, v);
      chk("unmapped", 16'h0000, v);
      // hold off: read reload while counting, no rise lost
      wr(A_RLO, 16'h1000, 2);
      ev(1'b0);
      tick(2);
      r0 = rises;
      run <= 1'b1;
      rd(A_RLO, v);
      tick(0);
      chk("reload running", 16'h1000, v);
      rd(A_CLO, v);
      chk("count no gate", 16'h1000 - 16'(rises - r0), v);
      // hold on: write while counting, rises in the window dropped
      i_hold_en <= 1'b1;
      ev(1'b1);
      tick(2);
      r0 = rises;
      run <= 1'b1;
      wr(A_RLO, 16'h2000, 2);
      tick(0);
      rd(A_CLO, v);
      p = (rises - r0) - int'(16'h1000 - v);
      chk("dropped rises", 16'h0001, {15'h0000, p >= 8 && p <= 14});
      rd(A_RLO, v);
      chk("reload held write", 16'h2000, v);
      ev(1'b0);
      tick(2);
      rd(A_CLO, v);
      chk("count held write", 16'h2000, v);
      // second reset with the counter clock parked clears the count register
      i_sys_rst <= 1'b1;
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      repeat (4) @(posedge i_clk);
      rd(A_CLO, v);
      chk("count after reset", 16'h0000, v);
      test_done();
   end
endmodule
